//--- verilog/rst_seq_pkg.sv
// Purpose: Shared constants for the reset and stop-recovery sequencer.
// Assumes: All counts are in oscillator reference clock cycles.
// Notes: Register offsets are byte addresses on a 32-bit APB.
`default_nettype none
package rst_seq_pkg;
  localparam int unsigned LONG_DELAY_CYC = 4096;
  localparam int unsigned SHORT_DELAY_CYC = 32;
  localparam int unsigned PIN_HOLD_CYC = 32;
  localparam int unsigned CPU_HOLD_CYC = 32;
  localparam int unsigned CNT_W = 12;
  localparam int unsigned MIN_EXT_PULSE_CYC = 4;
  localparam logic [11:0] OFS_CAUSE = 12'h000;
  localparam logic [11:0] OFS_CONFIG = 12'h004;
  localparam logic [11:0] OFS_WDOG = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00c;
  localparam int unsigned CFG_SHORT_STOP_BIT = 0;
  localparam int unsigned CFG_STOP_EN_BIT = 1;
  localparam int unsigned CFG_DIV4_BIT = 2;
  localparam logic [2:0] CFG_RESET = 3'h6;
  localparam int unsigned FLAG_BROWNOUT = 1;
  localparam int unsigned FLAG_BAD_FETCH = 3;
  localparam int unsigned FLAG_BAD_OPCODE = 4;
  localparam int unsigned FLAG_WATCHDOG = 5;
  localparam int unsigned FLAG_EXTERNAL = 6;
  localparam int unsigned FLAG_POWER_ON = 7;
  localparam logic [7:0] CAUSE_RESET = 8'h80;
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_BREAK = 16'hfffc;
  localparam logic [15:0] VEC_IRQ = 16'hfffa;
  localparam logic [15:0] VEC_KEYPAD = 16'hffde;
  localparam logic [15:0] VEC_TIMEBASE = 16'hffdc;
  typedef enum logic [2:0] {
    ST_POR_DELAY = 3'h0,
    ST_PIN_HOLD = 3'h1,
    ST_CPU_HOLD = 3'h3,
    ST_RUN = 3'h2,
    ST_STOP = 3'h6,
    ST_RECOVER = 3'h7,
    ST_LOW_WAIT = 3'h5,
    ST_EXT_WAIT = 3'h4
  } seq_state_e;
endpackage : rst_seq_pkg
`default_nettype wire

//--- verilog/delay_counter.sv
// Purpose: Down counter that times one sequencer phase.
// Assumes: A load of N makes o_zero high N cycles later.
// Notes: The reset value lets a power-on start timing at once.
`timescale 1ns/1ps
`default_nettype none
module delay_counter #(
  parameter int unsigned W = 12,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [W-1:0] i_value,
  output logic o_zero
);
  logic [W-1:0] cnt;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt <= RST_VAL;
    end else if (i_load) begin
      cnt <= i_value;
    end else if (cnt != '0) begin
      cnt <= cnt - 1'b1;
    end
  end

  assign o_zero = (cnt == '0);
endmodule : delay_counter
`default_nettype wire

//--- verilog/cause_flag.sv
// Purpose: One sticky reset-cause flag, cleared by a register read and reloaded to RST_VAL by power-on.
// Assumes: A set in the cycle of the clearing read survives it.
// Notes: RST_VAL gives the flag's value after a power-on reset.
`timescale 1ns/1ps
`default_nettype none
module cause_flag #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_set,
  input wire logic i_clr,
  output logic o_q
);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_q <= RST_VAL;
    end else if (i_set) begin
      o_q <= 1'b1;
    end else if (i_clr) begin
      o_q <= 1'b0;
    end
  end
endmodule : cause_flag
`default_nettype wire

//--- verilog/reset_and_stop_recovery_sequencer.sv
// Purpose: Reset and stop-recovery sequencer with reset-cause register.
// Assumes: i_clk_sys is the oscillator reference clock; i_rst is power-on.
// Notes: The reset pin is open drain; it is only ever driven low.
// Notes on behaviour
// - Stop is left on reset, brownout, irq/keypad fall, break or timebase.
// - Stop exit gates system clocks for 4096 reference cycles.
// - Short stop recovery select shortens the stop exit delay to 32 cycles.
// - Any reset aborts the CPU at once and restarts from the reset vector.
// - Any reset selects reference clock divided by four as bus clock.
// - Reset pin held low long enough causes reset and sets external flag.
// - Internal reset drives pin low 32 cycles, then holds CPU 32 more.
// - Power-on gates clocks 4096 cycles with pin low, then 32 and 64.
// - Power-on sets its own flag and clears every other cause flag.
// - Watchdog overflow gives an internal reset and sets watchdog flag.
// - Any write to the watchdog address clears the watchdog counter.
// - Brownout holds pin low while low, then 4096, 32, 64 cycles; flag set.
// - Illegal opcode gives an internal reset and sets bad opcode flag.
// - Stop instruction with stop disabled counts as an illegal opcode.
// - Opcode fetch from unmapped address resets and sets bad fetch flag.
// - Data access to an unmapped address causes no reset.
// - Cause register is read only; a read clears all flags afterwards.
// - Flags accumulate over resets until a read clears them.
// - Pin sampled 32 cycles after release; low sets the external flag.
// - Flag is 1 after its reset, 0 after a read or power-on.
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module reset_and_stop_recovery_sequencer #(
  parameter int unsigned MIN_EXT_PULSE = rst_seq_pkg::MIN_EXT_PULSE_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_rst_pin_in,
  output logic o_rst_pin_out,
  output logic o_rst_pin_oe,
  input wire logic i_brownout,
  input wire logic i_wdog_overflow,
  input wire logic i_bad_opcode,
  input wire logic i_stop_exec,
  input wire logic i_fetch_unmapped,
  input wire logic i_data_unmapped,
  input wire logic i_irq_fall,
  input wire logic i_keypad_fall,
  input wire logic i_break_irq,
  input wire logic i_timebase_roll,
  output logic o_sys_clk_run,
  output logic o_cpu_rst,
  output logic o_vector_fetch,
  output logic [15:0] o_vector_addr,
  output logic o_bus_clk_div4,
  output logic o_wdog_clear
);
  localparam int unsigned CW = rst_seq_pkg::CNT_W;
  localparam logic [CW-1:0] LOAD_LONG = CW'(rst_seq_pkg::LONG_DELAY_CYC - 1);
  localparam logic [CW-1:0] LOAD_SHORT = CW'(rst_seq_pkg::SHORT_DELAY_CYC - 1);
  localparam logic [CW-1:0] LOAD_PIN = CW'(rst_seq_pkg::PIN_HOLD_CYC - 1);
  localparam logic [CW-1:0] LOAD_CPU = CW'(rst_seq_pkg::CPU_HOLD_CYC - 1);

  rst_seq_pkg::seq_state_e state;
  rst_seq_pkg::seq_state_e next_state;
  logic [2:0] cfg;
  logic [7:0] cause;
  logic [7:0] cause_set;
  logic [CW-1:0] load_value;
  logic [15:0] next_vector;
  logic [15:0] wake_vector;
  logic [15:0] ext_low_cnt;
  logic cnt_zero;
  logic ext_reset;
  logic bad_opcode;
  logic internal_reset;
  logic from_stop;
  logic apb_done;
  logic cause_read;
  logic any_reset;
  logic [31:0] next_rdata;
  logic addr_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Reset and wake decisions.

  // The pin is only watched while the block is not driving it itself.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ext_low_cnt <= 16'h0000;
    end else if (i_rst_pin_in || o_rst_pin_oe) begin
      ext_low_cnt <= 16'h0000;
    end else if (ext_low_cnt != 16'hffff) begin
      ext_low_cnt <= ext_low_cnt + 16'h0001;
    end
  end

  always_comb begin
    ext_reset = (32'(ext_low_cnt) + 32'd1 >= MIN_EXT_PULSE) &&
      !i_rst_pin_in && !o_rst_pin_oe && (state == rst_seq_pkg::ST_RUN ||
      state == rst_seq_pkg::ST_STOP || state == rst_seq_pkg::ST_RECOVER);
    bad_opcode = i_bad_opcode ||
      (i_stop_exec && !cfg[rst_seq_pkg::CFG_STOP_EN_BIT]);
    // Data accesses to unmapped space never reach the reset logic.
    internal_reset = (state == rst_seq_pkg::ST_RUN) &&
      (i_wdog_overflow || bad_opcode || i_fetch_unmapped);
  end

  always_comb begin
    if (i_break_irq) begin
      wake_vector = rst_seq_pkg::VEC_BREAK;
    end else if (i_irq_fall) begin
      wake_vector = rst_seq_pkg::VEC_IRQ;
    end else if (i_keypad_fall) begin
      wake_vector = rst_seq_pkg::VEC_KEYPAD;
    end else begin
      wake_vector = rst_seq_pkg::VEC_TIMEBASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer state machine.

  always_comb begin
    next_state = state;
    load_value = LOAD_PIN;
    next_vector = o_vector_addr;
    case (state)
      rst_seq_pkg::ST_POR_DELAY: begin
        if (cnt_zero) begin
          next_state = rst_seq_pkg::ST_PIN_HOLD;
          load_value = LOAD_PIN;
        end
      end
      rst_seq_pkg::ST_LOW_WAIT: begin
        if (!i_brownout) begin
          next_state = rst_seq_pkg::ST_POR_DELAY;
          load_value = LOAD_LONG;
        end
      end
      rst_seq_pkg::ST_PIN_HOLD: begin
        if (cnt_zero) begin
          next_state = rst_seq_pkg::ST_CPU_HOLD;
          load_value = LOAD_CPU;
        end
      end
      rst_seq_pkg::ST_CPU_HOLD: begin
        if (cnt_zero) begin
          next_state = rst_seq_pkg::ST_RUN;
          next_vector = rst_seq_pkg::VEC_RESET;
        end
      end
      rst_seq_pkg::ST_EXT_WAIT: begin
        if (i_rst_pin_in) begin
          // A reset that woke the part from stop still waits out the
          // oscillator delay before the clocks may run.
          next_state = from_stop ? rst_seq_pkg::ST_RECOVER :
                                   rst_seq_pkg::ST_CPU_HOLD;
          load_value = from_stop ? LOAD_LONG : LOAD_CPU;
          next_vector = rst_seq_pkg::VEC_RESET;
        end
      end
      rst_seq_pkg::ST_RUN: begin
        if (i_stop_exec && cfg[rst_seq_pkg::CFG_STOP_EN_BIT]) begin
          next_state = rst_seq_pkg::ST_STOP;
        end
      end
      rst_seq_pkg::ST_STOP: begin
        if (i_irq_fall || i_keypad_fall || i_break_irq ||
            i_timebase_roll) begin
          next_state = rst_seq_pkg::ST_RECOVER;
          load_value = cfg[rst_seq_pkg::CFG_SHORT_STOP_BIT] ?
                       LOAD_SHORT : LOAD_LONG;
          next_vector = wake_vector;
        end
      end
      rst_seq_pkg::ST_RECOVER: begin
        if (cnt_zero) begin
          next_state = rst_seq_pkg::ST_RUN;
        end
      end
      default: begin
        next_state = rst_seq_pkg::ST_POR_DELAY;
        load_value = LOAD_LONG;
      end
    endcase
    // Resets override run, stop and recover (internal: run only); brownout overrides any phase, first since it holds the pin.
    if (i_brownout && state != rst_seq_pkg::ST_LOW_WAIT) begin
      next_state = rst_seq_pkg::ST_LOW_WAIT;
    end else if (ext_reset) begin
      next_state = rst_seq_pkg::ST_EXT_WAIT;
    end else if (internal_reset) begin
      next_state = rst_seq_pkg::ST_PIN_HOLD;
      load_value = LOAD_PIN;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state <= rst_seq_pkg::ST_POR_DELAY;
    end else begin
      state <= next_state;
    end
  end

  delay_counter #(
    .W(CW),
    .RST_VAL(LOAD_LONG)
  ) u_delay (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_load(next_state != state),
    .i_value(load_value),
    .o_zero(cnt_zero)
  );

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      from_stop <= 1'b0;
    end else if (ext_reset) begin
      from_stop <= (state == rst_seq_pkg::ST_STOP ||
                    state == rst_seq_pkg::ST_RECOVER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs to the core and the reset pin.

  assign any_reset = i_brownout || ext_reset || internal_reset;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sys_clk_run <= 1'b0;
      o_cpu_rst <= 1'b1;
      o_rst_pin_oe <= 1'b1;
      o_rst_pin_out <= 1'b0;
      o_vector_fetch <= 1'b0;
      o_vector_addr <= rst_seq_pkg::VEC_RESET;
    end else begin
      o_sys_clk_run <= !(next_state == rst_seq_pkg::ST_POR_DELAY ||
        next_state == rst_seq_pkg::ST_LOW_WAIT ||
        next_state == rst_seq_pkg::ST_STOP ||
        next_state == rst_seq_pkg::ST_RECOVER);
      o_cpu_rst <= !(next_state == rst_seq_pkg::ST_RUN ||
        next_state == rst_seq_pkg::ST_STOP ||
        next_state == rst_seq_pkg::ST_RECOVER);
      o_rst_pin_oe <= (next_state == rst_seq_pkg::ST_POR_DELAY ||
        next_state == rst_seq_pkg::ST_LOW_WAIT ||
        next_state == rst_seq_pkg::ST_PIN_HOLD);
      o_rst_pin_out <= 1'b0;
      o_vector_fetch <= (next_state == rst_seq_pkg::ST_RUN) &&
                        (state != rst_seq_pkg::ST_RUN);
      o_vector_addr <= next_vector;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset-cause flags.

  always_comb begin
    cause_set = 8'h00;
    cause_set[rst_seq_pkg::FLAG_BROWNOUT] = i_brownout;
    cause_set[rst_seq_pkg::FLAG_EXTERNAL] = ext_reset ||
      (state == rst_seq_pkg::ST_CPU_HOLD && cnt_zero &&
       !i_rst_pin_in);
    cause_set[rst_seq_pkg::FLAG_WATCHDOG] = internal_reset &&
      i_wdog_overflow;
    cause_set[rst_seq_pkg::FLAG_BAD_OPCODE] = internal_reset &&
      bad_opcode;
    cause_set[rst_seq_pkg::FLAG_BAD_FETCH] = internal_reset &&
      i_fetch_unmapped;
  end

  // Unused positions never set, so they read as zero.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      cause_flag #(
        .RST_VAL(rst_seq_pkg::CAUSE_RESET[gi])
      ) u_flag (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_set(cause_set[gi]),
        .i_clr(cause_read),
        .o_q(cause[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: no wait state, answer in the first access cycle.

  assign apb_done = i_psel && i_penable && o_pready;
  assign cause_read = apb_done && !i_pwrite &&
                      i_paddr == rst_seq_pkg::OFS_CAUSE;
  assign addr_ok = i_paddr == rst_seq_pkg::OFS_CAUSE ||
    i_paddr == rst_seq_pkg::OFS_CONFIG || i_paddr == rst_seq_pkg::OFS_WDOG ||
    i_paddr == rst_seq_pkg::OFS_STATUS;

  always_comb begin
    case (i_paddr)
      rst_seq_pkg::OFS_CAUSE: next_rdata = {24'h000000, cause};
      rst_seq_pkg::OFS_CONFIG: next_rdata = {29'h0, cfg};
      rst_seq_pkg::OFS_STATUS: next_rdata = {26'h0, o_cpu_rst,
                                             o_sys_clk_run, 1'b0, state};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h00000000;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !addr_ok;
      o_prdata <= (i_psel && !i_penable && !i_pwrite) ? next_rdata :
                  32'h00000000;
    end
  end

  // Reset re-selects the slow bus clock even if software picked another.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cfg <= rst_seq_pkg::CFG_RESET;
    end else if (any_reset) begin
      cfg[rst_seq_pkg::CFG_DIV4_BIT] <= 1'b1;
    end else if (apb_done && i_pwrite &&
                 i_paddr == rst_seq_pkg::OFS_CONFIG) begin
      cfg <= i_pwdata[2:0];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_bus_clk_div4 <= 1'b1;
      o_wdog_clear <= 1'b0;
    end else begin
      o_bus_clk_div4 <= cfg[rst_seq_pkg::CFG_DIV4_BIT] || any_reset;
      o_wdog_clear <= apb_done && i_pwrite &&
                      i_paddr == rst_seq_pkg::OFS_WDOG;
    end
  end
endmodule : reset_and_stop_recovery_sequencer
`default_nettype wire

//--- testbench/rst_seq_checker.sv
// Purpose: Port checker for the reset and stop-recovery sequencer.
// Assumes: One clock domain; power-on reset i_rst disables every check.
// Notes: Stop wake timing is only bounded for the short recovery case.
`timescale 1ns/1ps
`default_nettype none
module rst_seq_checker (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_rst_pin_oe,
  input wire logic i_rst_pin_in,
  input wire logic i_brownout,
  input wire logic i_wdog_overflow,
  input wire logic i_bad_opcode,
  input wire logic i_stop_exec,
  input wire logic i_fetch_unmapped,
  input wire logic i_data_unmapped,
  input wire logic i_keypad_fall,
  input wire logic o_sys_clk_run,
  input wire logic o_cpu_rst,
  input wire logic o_vector_fetch,
  input wire logic [15:0] o_vector_addr,
  input wire logic o_bus_clk_div4,
  input wire logic o_wdog_clear
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  // Mirrors the short recovery select bit, since the long wake is not bounded.
  logic short_sel;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      short_sel <= 1'b0;
    end else if (i_psel && i_penable && o_pready && i_pwrite &&
                 i_paddr == 12'h004) begin
      short_sel <= i_pwdata[0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_stopped;
    !o_sys_clk_run && !o_cpu_rst;
  endsequence
  sequence s_key_vec;
    o_vector_fetch && o_vector_addr == 16'hffde;
  endsequence
  sequence s_reset_vec;
    !o_cpu_rst && o_vector_fetch && o_vector_addr == 16'hfffe;
  endsequence
  a_pin_low_len: assert property ($rose(o_rst_pin_oe) && !i_brownout |->
    ##31 o_rst_pin_oe ##1 !o_rst_pin_oe) else $error("pin hold length");
  a_cpu_hold_len: assert property ($fell(o_rst_pin_oe) |->
    o_cpu_rst ##31 o_cpu_rst ##1 s_reset_vec) else $error("cpu hold length");
  a_div4_on_reset: assert property ($rose(o_cpu_rst) |-> o_bus_clk_div4)
    else $error("bus clock not div4");
  a_wdog_resets: assert property (o_sys_clk_run && !o_cpu_rst &&
    i_wdog_overflow |=> o_cpu_rst && o_rst_pin_oe) else $error("no reset");
  a_data_no_reset: assert property (i_data_unmapped && !o_cpu_rst &&
    i_rst_pin_in && !i_brownout && !(i_wdog_overflow || i_bad_opcode ||
    i_stop_exec || i_fetch_unmapped) |=> !o_cpu_rst) else $error("reset");
  a_short_wake: assert property (s_stopped and
    (i_keypad_fall && short_sel) |->
    !o_sys_clk_run [*8] ##[22:26] s_key_vec) else $error("wake timing");
  a_wdog_clear: assert property (i_psel && i_penable && o_pready &&
    i_pwrite && i_paddr == 12'h008 |=> o_wdog_clear ##1 !o_wdog_clear)
    else $error("watchdog clear pulse");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("ready too long");
  a_ready_wait: assert property (i_psel && !i_penable |=> o_pready)
    else $error("ready late");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_fetch_pulse: assert property (o_vector_fetch |=> !o_vector_fetch)
    else $error("fetch too long");
endmodule : rst_seq_checker
`default_nettype wire

//--- testbench/reset_pin_partner.sv
// Purpose: Far side of the open-drain reset pin with a pull-up.
// Assumes: An external device may pull the pin low on command.
// Notes: Released pin reads high through the pull-up.
`timescale 1ns/1ps
`default_nettype none
module reset_pin_partner (
  input wire logic i_oe,
  input wire logic i_out,
  input wire logic i_hold_low,
  output logic o_pin
);
  // The pull-up only wins when neither side pulls the line low.
  assign o_pin = (!i_oe || i_out) && !i_hold_low;
endmodule : reset_pin_partner
`default_nettype wire

//--- testbench/reset_and_stop_recovery_sequencer_test.sv
// Purpose: Self-checking bench for the reset and stop-recovery sequencer.
// Assumes: Design answers APB with no wait state; master waits anyway.
// Notes: Cycle windows allow up to four edges of slack around each documented count.
`timescale 1ns/1ps
`default_nettype none
module reset_and_stop_recovery_sequencer_test;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, hold = 1'b0;
  logic [11:0] i_paddr = 12'h000;
  logic [31:0] i_pwdata = 32'h0, o_prdata, q;
  logic [3:0] ev = 4'h0, wk = 4'h0;
  logic bo = 1'b0, dat = 1'b0, stp = 1'b0, e, pin, oe, run, crst, vf, div4;
  logic rdy, pout;
  logic [15:0] v;
  int errors = 0;
  int cmp_count = 0;
  int n;
  initial forever #2 i_clk_sys = ~i_clk_sys;
  reset_pin_partner far (.i_oe(oe), .i_out(pout), .i_hold_low(hold),
    .o_pin(pin));
  reset_and_stop_recovery_sequencer dut (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(rdy), .o_pslverr(e), .i_rst_pin_in(pin),
    .o_rst_pin_out(pout), .o_rst_pin_oe(oe), .i_brownout(bo),
    .i_wdog_overflow(ev[0]), .i_bad_opcode(ev[1]), .i_stop_exec(stp),
    .i_fetch_unmapped(ev[2]), .i_data_unmapped(dat), .i_irq_fall(wk[0]),
    .i_keypad_fall(wk[1]), .i_break_irq(wk[2]), .i_timebase_roll(wk[3]),
    .o_sys_clk_run(run), .o_cpu_rst(crst), .o_vector_fetch(vf),
    .o_vector_addr(v), .o_bus_clk_div4(div4), .o_wdog_clear());
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_in(input int got, input int lo, input int hi);
    chk(32'(got >= lo && got <= hi), 32'h1);
  endtask : chk_in
  // Read data is taken at the same edge that samples pready high.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (rdy !== 1'b1 && k < 20);
    q = o_prdata;
    if (rdy !== 1'b1) begin
      errors++;
      print_verdict();
    end
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic wait_fetch(input int lo, input int hi, input logic [15:0] ev_v);
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (vf !== 1'b1 && n < hi + 10);
    if (vf !== 1'b1) begin
      errors++;
      print_verdict();
    end
    chk_in(n, lo, hi);
    chk({16'h0, v}, {16'h0, ev_v});
  endtask : wait_fetch
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_por();
    wait_fetch(4158, 4164, 16'hfffe);
    rd(12'h000, 32'h80);
    rd(12'h000, 32'h00);
    rd(12'h004, 32'h6);
    rd(12'h00c, 32'h12);
    apb(1'b0, 12'h040, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h000, 32'hff);
    rd(12'h000, 32'h00);
    apb(1'b1, 12'h008, 32'h5a);
    $display("test por done");
  endtask : t_por
  task automatic t_internal();
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 12'h004, 32'h2);
      repeat (2) @(posedge i_clk_sys);
      chk({31'h0, div4}, 32'h0);
      @(posedge i_clk_sys) ev[k] <= 1'b1;
      @(posedge i_clk_sys) ev[k] <= 1'b0;
      wait_fetch(64, 66, 16'hfffe);
      chk({31'h0, div4}, 32'h1);
    end
    rd(12'h000, 32'h38);
    @(posedge i_clk_sys) dat <= 1'b1;
    @(posedge i_clk_sys) dat <= 1'b0;
    repeat (80) @(posedge i_clk_sys);
    rd(12'h000, 32'h00);
    $display("test internal done");
  endtask : t_internal
  task automatic t_stop();
    logic [15:0] vec [4] = '{16'hfffa, 16'hffde, 16'hfffc, 16'hffdc};
    apb(1'b1, 12'h004, 32'h4);
    @(posedge i_clk_sys) stp <= 1'b1;
    @(posedge i_clk_sys) stp <= 1'b0;
    wait_fetch(64, 66, 16'hfffe);
    rd(12'h000, 32'h10);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 12'h004, (k < 4) ? 32'h7 : 32'h6);
      @(posedge i_clk_sys) stp <= 1'b1;
      @(posedge i_clk_sys) stp <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
      chk({30'h0, run, crst}, 32'h0);
      wk[k % 4] <= 1'b1;
      @(posedge i_clk_sys) wk[k % 4] <= 1'b0;
      if (k < 4) wait_fetch(31, 35, vec[k]);
      else wait_fetch(4094, 4100, vec[0]);
    end
    rd(12'h000, 32'h00);
    @(posedge i_clk_sys) stp <= 1'b1;
    @(posedge i_clk_sys) stp <= 1'b0;
    @(posedge i_clk_sys) hold <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    hold <= 1'b0;
    wait_fetch(4094, 4100, 16'hfffe);
    rd(12'h000, 32'h40);
    $display("test stop done");
  endtask : t_stop
  task automatic t_pin();
    @(posedge i_clk_sys) hold <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    hold <= 1'b0;
    wait_fetch(31, 36, 16'hfffe);
    rd(12'h000, 32'h40);
    @(posedge i_clk_sys) ev[0] <= 1'b1;
    @(posedge i_clk_sys) ev[0] <= 1'b0;
    repeat (40) @(posedge i_clk_sys);
    hold <= 1'b1;
    repeat (24) @(posedge i_clk_sys);
    hold <= 1'b0;
    wait_fetch(1, 2, 16'hfffe);
    @(posedge i_clk_sys) bo <= 1'b1;
    repeat (10) @(posedge i_clk_sys);
    chk({30'h0, oe, pout}, 32'h2);
    bo <= 1'b0;
    wait_fetch(4158, 4164, 16'hfffe);
    rd(12'h000, 32'h62);
    @(posedge i_clk_sys) ev[2] <= 1'b1;
    @(posedge i_clk_sys) ev[2] <= 1'b0;
    wait_fetch(64, 66, 16'hfffe);
    @(posedge i_clk_sys) i_rst <= 1'b1;
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    wait_fetch(4158, 4164, 16'hfffe);
    rd(12'h000, 32'h80);
    $display("test pin done");
  endtask : t_pin
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_por();
    t_internal();
    t_stop();
    t_pin();
    print_verdict();
  end
endmodule : reset_and_stop_recovery_sequencer_test
bind reset_and_stop_recovery_sequencer rst_seq_checker chk_u (.*);
`default_nettype wire
